// ---- core/ufsm_pkg.sv ----
/*
  Package for the user-side layer 1 fault state machine: state codes,
  error causes, transmit selections and timing constants.
  Assumes a single 25 MHz system clock.
*/
`default_nettype none
package ufsm_pkg;

  typedef enum logic [6:0] {
    ST_POWER_OFF      = 7'h01,
    ST_OPERATIONAL    = 7'h02,
    ST_REMOTE_FAULT   = 7'h04,
    ST_SIGNAL_LOST    = 7'h08,
    ST_ALARM_STREAM   = 7'h10,
    ST_UPSTREAM_FAULT = 7'h20,
    ST_POWER_UP       = 7'h40
  } ufsm_state_e;

  // Management error causes
  localparam logic [2:0] CAUSE_POWER      = 3'h0;
  localparam logic [2:0] CAUSE_REMOTE     = 3'h1;
  localparam logic [2:0] CAUSE_LOSS       = 3'h2;
  localparam logic [2:0] CAUSE_ALARM      = 3'h3;
  localparam logic [2:0] CAUSE_REMOTE_CRC = 3'h4;

  // Transmit selection
  localparam logic [1:0] TX_NONE   = 2'h0;
  localparam logic [1:0] TX_NORMAL = 2'h1;
  localparam logic [1:0] TX_RAI    = 2'h2;

  // Received-signal classes after the event decoder
  localparam logic [2:0] EV_NONE      = 3'h0;
  localparam logic [2:0] EV_NORMAL    = 3'h1;
  localparam logic [2:0] EV_REMOTE    = 3'h2;
  localparam logic [2:0] EV_LOSS      = 3'h3;
  localparam logic [2:0] EV_ALARM     = 3'h4;
  localparam logic [2:0] EV_REMOTE_CRC = 3'h5;

  // Link clock watchdog: link period 320 ns, declare loss after 4 periods
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned LINK_LOSS_NS       = 1280;
  localparam int unsigned LINK_LOSS_CYC      = LINK_LOSS_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES        = 2;
  localparam logic [1:0]  RST_SYNC           = 2'h0;

endpackage : ufsm_pkg
`default_nettype wire

// ---- core/ufsm_sync.sv ----
/*
  Two-flop synchroniser, one per bit via a generate loop.
  Assumes the inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ufsm_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_r;
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          meta_r   <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_r   <= async_i[g];
          sync_o[g] <= meta_r;
        end
      end
    end
  endgenerate

endmodule // ufsm_sync
`default_nettype wire

// ---- core/ufsm_top.sv ----
/*
  User-side layer 1 operation and maintenance state machine for a
  2048 kbit/s cell interface. Classifies detected line events, steps the
  fault states, issues upper-layer and management indications and selects
  the transmit signal and timing source.
  Assumes defect detectors, framer and CRC logic are outside; all their
  flags arrive asynchronously, as does the recovered link clock.
*/
// Overview of operation
// - Alarm stream: no network timing, send RAI
// - Upstream fault: keep timing, normal frames, CRC optional
// - Power-up transient, silent, leaves after classification
// - Normal frames in fault: go operational, indicate
// - Leaving operational issues upper inactive indication
// - Management activate reports return to operational
// - Fault entry issues error indication with cause
// - Correction indication names the corrected failure
// - Coinciding faults resolved by fixed priority
// - Four fault locations map to four states
// - Remote alarm plus continuous CRC means upstream fault
// - Signal lost: RAI from internal oscillator
// - Operational: report received CRC errors back
`timescale 1ns/1ps
`default_nettype none
module ufsm_top #(
  parameter bit CRC_OPTION = 1'b1
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       POWER_OK_I,
  input  wire logic       LINK_CLK_I,
  input  wire logic       LOS_I,
  input  wire logic       LOF_I,
  input  wire logic       LCD_I,
  input  wire logic       AIS_I,
  input  wire logic       RAI_I,
  input  wire logic       CRC_CONT_I,
  input  wire logic       CRC_ERR_I,
  input  wire logic       CRC_REPORT_EN_I,
  output logic            UPPER_ACTIVE_IND_O,
  output logic            UPPER_INACTIVE_IND_O,
  output logic            MGMT_ACTIVATE_IND_O,
  output logic            MGMT_ERROR_IND_O,
  output logic [2:0]      MGMT_ERROR_CAUSE_O,
  output logic            MGMT_CORRECT_IND_O,
  output logic [2:0]      MGMT_CORRECT_CAUSE_O,
  output logic [1:0]      TX_SEL_O,
  output logic            TX_CRC_ERR_O,
  output logic            TIMING_INTERNAL_O,
  output logic [6:0]      STATE_O
);

  localparam int unsigned NIN = 10;

  logic [NIN-1:0] sync_w;
  logic           pwr_s;
  logic           lclk_s;
  logic           los_s;
  logic           lof_s;
  logic           lcd_s;
  logic           ais_s;
  logic           rai_s;
  logic           crc_cont_s;
  logic           crc_err_s;
  logic           crc_rep_s;

  ufsm_sync #(
    .WIDTH (NIN)
  ) u_sync (
    .clk_i   (REF_CLK_I),
    .rst_b_i (RST_B_I),
    .async_i ({POWER_OK_I, LINK_CLK_I, LOS_I, LOF_I, LCD_I, AIS_I, RAI_I,
               CRC_CONT_I, CRC_ERR_I, CRC_REPORT_EN_I}),
    .sync_o  (sync_w)
  );

  assign {pwr_s, lclk_s, los_s, lof_s, lcd_s, ais_s, rai_s, crc_cont_s, crc_err_s, crc_rep_s} = sync_w;

  // Link clock edge watchdog; a missing link clock is classified as loss of signal
  logic        lclk_d_r;
  logic [7:0]  idle_cnt_r;
  logic        link_ok_r;

  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      lclk_d_r   <= 1'b0;
      idle_cnt_r <= 8'h00;
      link_ok_r  <= 1'b0;
    end
    else
    begin
      lclk_d_r <= lclk_s;
      if (lclk_s && !lclk_d_r)
      begin
        idle_cnt_r <= 8'h00;
        link_ok_r  <= 1'b1;
      end
      else if (idle_cnt_r >= 8'(ufsm_pkg::LINK_LOSS_CYC))
        link_ok_r <= 1'b0;
      else
        idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  // Classify the received signal; loss outranks alarm stream, then remote alarm
  logic [2:0] ev_w;

  always_comb
  begin
    if (los_s || lof_s || lcd_s || !link_ok_r)
      ev_w = ufsm_pkg::EV_LOSS;
    else if (ais_s)
      ev_w = ufsm_pkg::EV_ALARM;
    else if (rai_s && crc_cont_s && CRC_OPTION)
      ev_w = ufsm_pkg::EV_REMOTE_CRC;
    else if (rai_s)
      ev_w = ufsm_pkg::EV_REMOTE;
    else
      ev_w = ufsm_pkg::EV_NORMAL;
  end

  ufsm_pkg::ufsm_state_e state_r;
  ufsm_pkg::ufsm_state_e state_nxt;
  logic [2:0]            cause_nxt;
  logic                  fault_nxt;

  // Event to fault state mapping, one location per state
  always_comb
  begin
    state_nxt = state_r;
    cause_nxt = ufsm_pkg::CAUSE_POWER;
    fault_nxt = 1'b0;
    case (state_r)
      ufsm_pkg::ST_POWER_OFF:
      begin
        if (pwr_s)
          state_nxt = ufsm_pkg::ST_POWER_UP;
      end
      default:
      begin
        if (!pwr_s)
        begin
          state_nxt = ufsm_pkg::ST_POWER_OFF;
          fault_nxt = 1'b1;
        end
        else
        begin
          case (ev_w)
            ufsm_pkg::EV_NORMAL:
              if (state_r != ufsm_pkg::ST_POWER_UP)
                state_nxt = ufsm_pkg::ST_OPERATIONAL;
            ufsm_pkg::EV_REMOTE:
            begin
              state_nxt = ufsm_pkg::ST_REMOTE_FAULT;
              cause_nxt = ufsm_pkg::CAUSE_REMOTE;
            end
            ufsm_pkg::EV_LOSS:
            begin
              state_nxt = ufsm_pkg::ST_SIGNAL_LOST;
              cause_nxt = ufsm_pkg::CAUSE_LOSS;
            end
            ufsm_pkg::EV_ALARM:
            begin
              state_nxt = ufsm_pkg::ST_ALARM_STREAM;
              cause_nxt = ufsm_pkg::CAUSE_ALARM;
            end
            ufsm_pkg::EV_REMOTE_CRC:
            begin
              state_nxt = ufsm_pkg::ST_UPSTREAM_FAULT;
              cause_nxt = ufsm_pkg::CAUSE_REMOTE_CRC;
            end
            default:
              state_nxt = state_r;
          endcase
          // Same fault again gives no move and no indication
          fault_nxt = (state_nxt != state_r) && (ev_w != ufsm_pkg::EV_NORMAL);
        end
      end
    endcase
  end

  // Power-up leaves as soon as the received signal is classified
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      state_r <= ufsm_pkg::ST_POWER_OFF;
    else if (state_r == ufsm_pkg::ST_POWER_UP && pwr_s && ev_w == ufsm_pkg::EV_NORMAL)
      state_r <= ufsm_pkg::ST_OPERATIONAL;
    else
      state_r <= state_nxt;
  end

  logic leave_op_w;
  logic enter_op_w;
  logic [2:0] last_cause_r;
  logic       in_fault_r;

  assign leave_op_w = (state_r == ufsm_pkg::ST_OPERATIONAL) && (state_nxt != ufsm_pkg::ST_OPERATIONAL);
  assign enter_op_w = (state_r != ufsm_pkg::ST_OPERATIONAL) && (state_r != ufsm_pkg::ST_POWER_OFF) && pwr_s &&
                      (ev_w == ufsm_pkg::EV_NORMAL);

  // One-cycle indications
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      UPPER_ACTIVE_IND_O   <= 1'b0;
      UPPER_INACTIVE_IND_O <= 1'b0;
      MGMT_ACTIVATE_IND_O  <= 1'b0;
      MGMT_ERROR_IND_O     <= 1'b0;
      MGMT_ERROR_CAUSE_O   <= 3'h0;
      MGMT_CORRECT_IND_O   <= 1'b0;
      MGMT_CORRECT_CAUSE_O <= 3'h0;
      last_cause_r         <= 3'h0;
      in_fault_r           <= 1'b0;
    end
    else
    begin
      UPPER_ACTIVE_IND_O   <= enter_op_w && (state_r != ufsm_pkg::ST_POWER_UP);
      UPPER_INACTIVE_IND_O <= leave_op_w;
      MGMT_ACTIVATE_IND_O  <= enter_op_w;
      MGMT_ERROR_IND_O     <= fault_nxt;
      MGMT_CORRECT_IND_O   <= enter_op_w && in_fault_r;
      if (fault_nxt)
      begin
        MGMT_ERROR_CAUSE_O <= cause_nxt;
        last_cause_r       <= cause_nxt;
        in_fault_r         <= (cause_nxt != ufsm_pkg::CAUSE_POWER);
      end
      if (enter_op_w)
      begin
        MGMT_CORRECT_CAUSE_O <= last_cause_r;
        in_fault_r           <= 1'b0;
      end
    end
  end

  // Transmit selection and timing source follow the state
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      TX_SEL_O          <= ufsm_pkg::TX_NONE;
      TX_CRC_ERR_O      <= 1'b0;
      TIMING_INTERNAL_O <= 1'b1;
      STATE_O           <= 7'h01;
    end
    else
    begin
      STATE_O <= state_r;
      case (state_r)
        ufsm_pkg::ST_OPERATIONAL, ufsm_pkg::ST_REMOTE_FAULT:
        begin
          TX_SEL_O          <= ufsm_pkg::TX_NORMAL;
          TX_CRC_ERR_O      <= crc_err_s;
          TIMING_INTERNAL_O <= 1'b0;
        end
        ufsm_pkg::ST_UPSTREAM_FAULT:
        begin
          TX_SEL_O          <= ufsm_pkg::TX_NORMAL;
          TX_CRC_ERR_O      <= crc_err_s && crc_rep_s;
          TIMING_INTERNAL_O <= 1'b0;
        end
        ufsm_pkg::ST_SIGNAL_LOST, ufsm_pkg::ST_ALARM_STREAM:
        begin
          TX_SEL_O          <= ufsm_pkg::TX_RAI;
          TX_CRC_ERR_O      <= 1'b0;
          TIMING_INTERNAL_O <= 1'b1;
        end
        default:
        begin
          TX_SEL_O          <= ufsm_pkg::TX_NONE;
          TX_CRC_ERR_O      <= 1'b0;
          TIMING_INTERNAL_O <= 1'b1;
        end
      endcase
    end
  end

endmodule // ufsm_top
`default_nettype wire

// ---- bench/ufsm_net_model.sv ----
/* Network-side model: line flags and link clock from a commanded state.
   Assumes the bench sets net_state_i off the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module ufsm_net_model (
  input  wire logic [2:0] net_state_i,
  output logic            link_clk_o,
  output logic            los_o,
  output logic            lof_o,
  output logic            lcd_o,
  output logic            ais_o,
  output logic            rai_o,
  output logic            crc_cont_o
);
  // 0 power-up, 1 oper, 2..5 fault 1..4, 6 frame loss, 7 cell loss
  logic run;
  assign run = net_state_i inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  assign los_o = net_state_i inside {3'h0, 3'h3};
  assign lof_o = net_state_i == 3'h6;
  assign lcd_o = net_state_i == 3'h7;
  assign ais_o = net_state_i == 3'h4;
  assign rai_o = net_state_i inside {3'h2, 3'h5};
  assign crc_cont_o = net_state_i == 3'h5;
  // Clock parks low when timing is withheld, as a dead line would
  initial
  begin
    link_clk_o = 1'b0;
    forever #160 link_clk_o = run ? ~link_clk_o : 1'b0;
  end
endmodule // ufsm_net_model
`default_nettype wire

// ---- bench/ufsm_checker.sv ----
/* Checker for ufsm_top: state, transmit and indication relations.
   Assumes it is bound onto the ports of ufsm_top. */
`timescale 1ns/1ps
`default_nettype none
module ufsm_checker (
  input wire logic       REF_CLK_I,
  input wire logic       RST_B_I,
  input wire logic       POWER_OK_I,
  input wire logic       UPPER_INACTIVE_IND_O,
  input wire logic       MGMT_ACTIVATE_IND_O,
  input wire logic       MGMT_ERROR_IND_O,
  input wire logic [2:0] MGMT_ERROR_CAUSE_O,
  input wire logic [1:0] TX_SEL_O,
  input wire logic       TIMING_INTERNAL_O,
  input wire logic [6:0] STATE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Top bit marks a state whose entry reports an error
  function automatic logic [3:0] cause_of(input logic [6:0] s);
    case (s)
      7'h01: return 4'h8;
      7'h04: return 4'h9;
      7'h08: return 4'hA;
      7'h10: return 4'hB;
      7'h20: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction
  // A function result cannot be bit-selected directly, so it goes through a net
  logic [3:0] cause_w;
  assign cause_w = cause_of(STATE_O);
  sequence s_hold(logic [6:0] s);
    STATE_O == s ##1 STATE_O == s;
  endsequence
  sequence s_left_oper;
    STATE_O == 7'h02 ##1 STATE_O != 7'h02;
  endsequence
  a_state_onehot: assert property ($onehot(STATE_O)) else $error("state not one-hot");
  a_off_silent: assert property (s_hold(7'h01) |-> TX_SEL_O == 2'h0) else $error("power-off transmits");
  a_powerup_silent: assert property (s_hold(7'h40) |-> TX_SEL_O == 2'h0) else $error("power-up transmits");
  a_rai_internal: assert property (s_hold(7'h08) or s_hold(7'h10)
    |-> TX_SEL_O == 2'h2 && TIMING_INTERNAL_O) else $error("alarm state transmit wrong");
  a_normal_network: assert property (s_hold(7'h02) or s_hold(7'h04) or s_hold(7'h20)
    |-> TX_SEL_O == 2'h1 && !TIMING_INTERNAL_O) else $error("normal transmit wrong");
  a_err_cause: assert property ($changed(STATE_O) && cause_w[3] |->
    MGMT_ERROR_CAUSE_O == cause_w[2:0] && ($past(MGMT_ERROR_IND_O) || MGMT_ERROR_IND_O))
    else $error("bad error ind");
  a_leave_inactive: assert property (s_left_oper |-> UPPER_INACTIVE_IND_O || $past(UPPER_INACTIVE_IND_O))
    else $error("no inactive ind");
  a_enter_activate: assert property (STATE_O == 7'h02 && $past(STATE_O) != 7'h02 |->
    MGMT_ACTIVATE_IND_O || $past(MGMT_ACTIVATE_IND_O)) else $error("no activate ind");
  a_err_single: assert property (MGMT_ERROR_IND_O |=> !MGMT_ERROR_IND_O) else $error("error ind too long");
  a_power_loss: assert property (!POWER_OK_I [*6] |-> STATE_O == 7'h01) else $error("power loss ignored");
endmodule // ufsm_checker
bind ufsm_top ufsm_checker u_ufsm_checker (.REF_CLK_I, .RST_B_I, .POWER_OK_I, .UPPER_INACTIVE_IND_O,
  .MGMT_ACTIVATE_IND_O, .MGMT_ERROR_IND_O, .MGMT_ERROR_CAUSE_O, .TX_SEL_O, .TIMING_INTERNAL_O, .STATE_O);
`default_nettype wire

// ---- bench/ufsm_top_tb.sv ----
/* Testbench for ufsm_top against the network-side model.
   Assumes 25 MHz clock; the model makes the 320 ns link clock. */
`timescale 1ns/1ps
`default_nettype none
module ufsm_top_tb;
  logic       clk, rst_b, pwr, crc_err, crc_en;
  logic [2:0] net_st, ecause, ccause;
  logic       lclk, los, lof, lcd, ais, rai, cont;
  logic       ua, ui, ma, me, mc, tcrc, tint;
  logic [1:0] txs;
  logic [6:0] st;
  logic [6:0] st2;
  int         fail_count = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n[5] = '{default: 0};

  ufsm_net_model u_ufsm_net_model (.net_state_i(net_st), .link_clk_o(lclk), .los_o(los), .lof_o(lof),
    .lcd_o(lcd), .ais_o(ais), .rai_o(rai), .crc_cont_o(cont));
  ufsm_top u_ufsm_top (.REF_CLK_I(clk), .RST_B_I(rst_b), .POWER_OK_I(pwr), .LINK_CLK_I(lclk), .LOS_I(los),
    .LOF_I(lof), .LCD_I(lcd), .AIS_I(ais), .RAI_I(rai), .CRC_CONT_I(cont), .CRC_ERR_I(crc_err),
    .CRC_REPORT_EN_I(crc_en), .UPPER_ACTIVE_IND_O(ua), .UPPER_INACTIVE_IND_O(ui), .MGMT_ACTIVATE_IND_O(ma),
    .MGMT_ERROR_IND_O(me), .MGMT_ERROR_CAUSE_O(ecause), .MGMT_CORRECT_IND_O(mc), .MGMT_CORRECT_CAUSE_O(ccause),
    .TX_SEL_O(txs), .TX_CRC_ERR_O(tcrc), .TIMING_INTERNAL_O(tint), .STATE_O(st));
  // Without the CRC option, remote alarm with continuous CRC errors must stay a remote fault
  ufsm_top #(.CRC_OPTION(1'b0)) u_ufsm_top_merged (.REF_CLK_I(clk), .RST_B_I(rst_b), .POWER_OK_I(pwr),
    .LINK_CLK_I(lclk), .LOS_I(los), .LOF_I(lof), .LCD_I(lcd), .AIS_I(ais), .RAI_I(rai), .CRC_CONT_I(cont),
    .CRC_ERR_I(crc_err), .CRC_REPORT_EN_I(crc_en), .UPPER_ACTIVE_IND_O(), .UPPER_INACTIVE_IND_O(),
    .MGMT_ACTIVATE_IND_O(), .MGMT_ERROR_IND_O(), .MGMT_ERROR_CAUSE_O(), .MGMT_CORRECT_IND_O(),
    .MGMT_CORRECT_CAUSE_O(), .TX_SEL_O(), .TX_CRC_ERR_O(), .TIMING_INTERNAL_O(), .STATE_O(st2));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses are one cycle wide, so counting at each edge loses none
  always @(posedge clk)
  begin
    n[0] += int'(ua);
    n[1] += int'(ui);
    n[2] += int'(ma);
    n[3] += int'(me);
    n[4] += int'(mc);
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("[ERR] %0t run hung", $time);
      final_report();
    end
  end

  task automatic final_report();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [6:0] got, input logic [6:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Pulse mask order: upper active, upper inactive, activate, error, correct
  task automatic step(input logic p, input logic [2:0] ns, input logic [6:0] es, input logic [4:0] ep,
                      input logic [2:0] ec);
    int         n0[5];
    logic [4:0] got;
    n0 = n;
    @(negedge clk);
    pwr = p;
    net_st = ns;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 80 && st !== es; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    for (int i = 0; i < 5; i++) got[4-i] = n[i] != n0[i];
    // Correction is only judged on a return to operation
    if (es != 7'h02) got[0] = 1'b0;
    chk(st, es, "state");
    chk(7'(got), 7'(ep), "pulses");
    if (ep[1]) chk(7'(ecause), 7'(ec), "error cause");
    if (ep[0]) chk(7'(ccause), 7'(ec), "correct cause");
    if (es inside {7'h01, 7'h40}) chk(7'(txs), 7'h0, "tx off");
    else chk(7'(txs), (es inside {7'h08, 7'h10}) ? 7'h2 : 7'h1, "tx");
    if (es inside {7'h08, 7'h10}) chk(7'(tint), 7'h1, "timing");
    else if (es != 7'h01) chk(7'(tint), 7'h0, "timing");
  endtask

  task automatic t_powerup();
    step(1'b1, 3'h1, 7'h02, 5'b00100, 3'h0);
  endtask

  task automatic t_faults();
    logic [2:0] nv[6] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};
    logic [6:0] sv[6] = '{7'h04, 7'h08, 7'h08, 7'h08, 7'h10, 7'h20};
    logic [2:0] cv[6] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h4};
    for (int i = 0; i < 6; i++)
    begin
      step(1'b1, nv[i], sv[i], 5'b01010, cv[i]);
      step(1'b1, 3'h1, 7'h02, 5'b10101, cv[i]);
    end
  endtask

  task automatic t_double();
    step(1'b1, 3'h4, 7'h10, 5'b01010, 3'h3);
    step(1'b1, 3'h2, 7'h04, 5'b00010, 3'h1);
    step(1'b1, 3'h2, 7'h04, 5'b00000, 3'h1);
    step(1'b1, 3'h5, 7'h20, 5'b00010, 3'h4);
    step(1'b1, 3'h3, 7'h08, 5'b00010, 3'h2);
    step(1'b1, 3'h1, 7'h02, 5'b10101, 3'h2);
  endtask

  task automatic t_crc();
    crc_err = 1'b1;
    repeat (8) @(negedge clk);
    chk(7'(tcrc), 7'h1, "crc report");
    step(1'b1, 3'h5, 7'h20, 5'b01010, 3'h4);
    chk(st2, 7'h04, "merged remote");
    crc_en = 1'b0;
    repeat (8) @(negedge clk);
    chk(7'(tcrc), 7'h0, "crc report off");
    crc_en = 1'b1;
    repeat (8) @(negedge clk);
    chk(7'(tcrc), 7'h1, "crc report on");
    crc_err = 1'b0;
    step(1'b1, 3'h1, 7'h02, 5'b10101, 3'h4);
  endtask

  task automatic t_power();
    step(1'b0, 3'h1, 7'h01, 5'b01010, 3'h0);
    step(1'b1, 3'h4, 7'h10, 5'b00010, 3'h3);
    step(1'b0, 3'h4, 7'h01, 5'b00010, 3'h0);
    step(1'b1, 3'h1, 7'h02, 5'b00100, 3'h0);
  endtask

  initial
  begin
    rst_b = 1'b0;
    pwr = 1'b0;
    crc_err = 1'b0;
    crc_en = 1'b1;
    net_st = 3'h1;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_powerup();
    t_faults();
    t_double();
    t_crc();
    t_power();
    final_report();
  end
endmodule // ufsm_top_tb
`default_nettype wire
